// File: rtl/bbse_core.sv
// execute stage for relative branches, i/o bit set/clear and shifts
// assumes a single in-order issuer on clk; every input is synchronous
`timescale 1ns/1ps
`include "bbse_map.svh"

module bbse_core (
   input wire logic clk,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire bbse_pkg::bbse_cmd_t cmd,
   input wire logic gpr_wr_en,
   input wire logic [`BBSE_ADR_W-1:0] gpr_wr_addr,
   input wire logic [7:0] gpr_wr_data,
   input wire logic flags_wr_en,
   input wire logic [7:0] flags_wr_data,
   input wire logic io_wr_en,
   input wire logic [`BBSE_ADR_W-1:0] io_wr_addr,
   input wire logic [7:0] io_wr_data,
   output logic cmd_ready,
   output logic done,
   output logic taken,
   output logic [`BBSE_PC_W-1:0] pc,
   output logic [7:0] flags,
   output logic [7:0] result,
   output logic [31:0][7:0] gpr_file,
   output logic [31:0][7:0] io_file
);

   localparam logic [1:0] BR_LAST =
      2'(`BBSE_BR_TAKEN_CYC - 1);
   localparam logic [1:0] IO_LAST =
      2'(`BBSE_IO_BIT_CYC - 1);

   bbse_pkg::bbse_state_t s_r;
   bbse_pkg::bbse_state_t s_nxt;

   // branch condition on the status word
   function automatic logic br_cond(
      input bbse_pkg::bbse_op_t op,
      input logic [7:0] f
   );
      logic n;
      logic v;
      n = f[`BBSE_FLAG_N];
      v = f[`BBSE_FLAG_V];
      br_cond = 1'b0;
      unique case (op)
         bbse_pkg::BBSE_OP_BR_PLUS: begin
            br_cond = (n == 1'b0);
         end
         bbse_pkg::BBSE_OP_BR_GE: begin
            br_cond = ((n ^ v) == 1'b0);
         end
         bbse_pkg::BBSE_OP_BR_LT: begin
            br_cond = ((n ^ v) == 1'b1);
         end
         bbse_pkg::BBSE_OP_BR_HS: begin
            br_cond = f[`BBSE_FLAG_H];
         end
         bbse_pkg::BBSE_OP_BR_HC: begin
            br_cond = !f[`BBSE_FLAG_H];
         end
         bbse_pkg::BBSE_OP_BR_TS: begin
            br_cond = f[`BBSE_FLAG_T];
         end
         bbse_pkg::BBSE_OP_BR_TC: begin
            br_cond = !f[`BBSE_FLAG_T];
         end
         bbse_pkg::BBSE_OP_BR_VS: begin
            br_cond = v;
         end
         bbse_pkg::BBSE_OP_BR_VC: begin
            br_cond = !v;
         end
         bbse_pkg::BBSE_OP_BR_IE: begin
            br_cond = f[`BBSE_FLAG_I];
         end
         bbse_pkg::BBSE_OP_BR_ID: begin
            br_cond = !f[`BBSE_FLAG_I];
         end
         bbse_pkg::BBSE_OP_SET_IO_BIT,
         bbse_pkg::BBSE_OP_CLR_IO_BIT,
         bbse_pkg::BBSE_OP_SHIFT_LEFT,
         bbse_pkg::BBSE_OP_SHIFT_RIGHT,
         bbse_pkg::BBSE_OP_ROT_CARRY: begin
            br_cond = 1'b0;
         end
      endcase
   endfunction

   // shifter: result and carry out
   function automatic bbse_pkg::bbse_shift_t do_shift(
      input bbse_pkg::bbse_op_t op,
      input logic [7:0] d,
      input logic cin
   );
      bbse_pkg::bbse_shift_t o;
      o.res = d;
      o.c = cin;
      if (op == bbse_pkg::BBSE_OP_SHIFT_LEFT) begin
         o.res = {d[6:0], 1'b0};
         o.c = d[7];
      end else if (op == bbse_pkg::BBSE_OP_SHIFT_RIGHT) begin
         o.res = {1'b0, d[7:1]};
         o.c = d[0];
      end else if (op == bbse_pkg::BBSE_OP_ROT_CARRY) begin
         o.res = {cin, d[7:1]};
         o.c = d[0];
      end
      do_shift = o;
   endfunction

   // pc of the next word in sequence
   function automatic logic [`BBSE_PC_W-1:0] pc_inc(
      input logic [`BBSE_PC_W-1:0] p
   );
      pc_inc = p + `BBSE_PC_W'(1);
   endfunction

   // relative target; k is signed, wraps in the pc space
   function automatic logic [`BBSE_PC_W-1:0] pc_rel(
      input logic [`BBSE_PC_W-1:0] p,
      input logic [`BBSE_K_W-1:0] k
   );
      logic [`BBSE_PC_W-1:0] kx;
      kx = `BBSE_PC_W'(signed'(k));
      pc_rel = pc_inc(p + kx);
   endfunction

   always_comb begin
      bbse_pkg::bbse_shift_t sh;
      logic [7:0] d;
      logic n;
      logic c;
      s_nxt = s_r;
      sh = '0;
      d = '0;
      n = 1'b0;
      c = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.taken = 1'b0;
      // side loads first so an executing op overrides them
      if (gpr_wr_en) begin
         s_nxt.gpr[gpr_wr_addr] = gpr_wr_data;
      end
      if (flags_wr_en) begin
         s_nxt.flags = flags_wr_data;
      end
      if (io_wr_en) begin
         s_nxt.io[io_wr_addr] = io_wr_data;
      end
      unique case (s_r.fsm)
         bbse_pkg::BBSE_ST_IDLE: begin
            if (cmd_valid && s_r.ready) begin
               s_nxt.cmd = cmd;
               unique case (cmd.op)
                  bbse_pkg::BBSE_OP_SET_IO_BIT,
                  bbse_pkg::BBSE_OP_CLR_IO_BIT: begin
                     // bit written on the second cycle
                     s_nxt.fsm = bbse_pkg::BBSE_ST_IO_BIT;
                     s_nxt.cnt = 2'h1;
                     s_nxt.ready = 1'b0;
                  end
                  bbse_pkg::BBSE_OP_SHIFT_LEFT,
                  bbse_pkg::BBSE_OP_SHIFT_RIGHT,
                  bbse_pkg::BBSE_OP_ROT_CARRY: begin
                     // operand seen after any side load
                     d = s_nxt.gpr[cmd.dst];
                     sh = do_shift(cmd.op, d,
                        s_r.flags[`BBSE_FLAG_C]);
                     n = sh.res[7];
                     c = sh.c;
                     s_nxt.gpr[cmd.dst] = sh.res;
                     s_nxt.result = sh.res;
                     s_nxt.flags = s_r.flags;
                     s_nxt.flags[`BBSE_FLAG_Z] =
                        (sh.res == 8'h00);
                     s_nxt.flags[`BBSE_FLAG_C] = c;
                     s_nxt.flags[`BBSE_FLAG_N] = n;
                     s_nxt.flags[`BBSE_FLAG_V] = n ^ c;
                     s_nxt.pc = pc_inc(s_r.pc);
                     s_nxt.done = 1'b1;
                  end
                  bbse_pkg::BBSE_OP_BR_PLUS,
                  bbse_pkg::BBSE_OP_BR_GE,
                  bbse_pkg::BBSE_OP_BR_LT,
                  bbse_pkg::BBSE_OP_BR_HS,
                  bbse_pkg::BBSE_OP_BR_HC,
                  bbse_pkg::BBSE_OP_BR_TS,
                  bbse_pkg::BBSE_OP_BR_TC,
                  bbse_pkg::BBSE_OP_BR_VS,
                  bbse_pkg::BBSE_OP_BR_VC,
                  bbse_pkg::BBSE_OP_BR_IE,
                  bbse_pkg::BBSE_OP_BR_ID: begin
                     // flags sampled at issue, never written
                     if (br_cond(cmd.op, s_r.flags)) begin
                        s_nxt.fsm = bbse_pkg::BBSE_ST_BRANCH;
                        s_nxt.cnt = 2'h1;
                        s_nxt.ready = 1'b0;
                     end else begin
                        s_nxt.pc = pc_inc(s_r.pc);
                        s_nxt.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         bbse_pkg::BBSE_ST_BRANCH: begin
            if (s_r.cnt == BR_LAST) begin
               s_nxt.pc = pc_rel(s_r.pc, s_r.cmd.k);
               s_nxt.taken = 1'b1;
               s_nxt.done = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.cnt = 2'h0;
               s_nxt.fsm = bbse_pkg::BBSE_ST_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt + 2'h1;
            end
         end
         bbse_pkg::BBSE_ST_IO_BIT: begin
            if (s_r.cnt == IO_LAST) begin
               if (s_r.cmd.op == bbse_pkg::BBSE_OP_SET_IO_BIT) begin
                  s_nxt.io[s_r.cmd.io_addr][s_r.cmd.bit_sel] =
                     1'b1;
               end else begin
                  s_nxt.io[s_r.cmd.io_addr][s_r.cmd.bit_sel] =
                     1'b0;
               end
               s_nxt.pc = pc_inc(s_r.pc);
               s_nxt.done = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.cnt = 2'h0;
               s_nxt.fsm = bbse_pkg::BBSE_ST_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt + 2'h1;
            end
         end
         default: begin
            // unused code: recover to idle
            s_nxt.fsm = bbse_pkg::BBSE_ST_IDLE;
            s_nxt.cnt = 2'h0;
            s_nxt.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.fsm <= bbse_pkg::BBSE_ST_IDLE;
         s_r.pc <= `BBSE_PC_RST;
         s_r.flags <= `BBSE_FLAGS_RST;
         s_r.result <= `BBSE_DATA_RST;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cmd_ready = s_r.ready;
   assign done = s_r.done;
   assign taken = s_r.taken;
   assign pc = s_r.pc;
   assign flags = s_r.flags;
   assign result = s_r.result;
   assign gpr_file = s_r.gpr;
   assign io_file = s_r.io;

endmodule

// File: rtl/bbse_map.svh
// constants for the branch / bit / shift execute stage
// assumes an 8-bit status word and 32 i/o and 32 general registers
`ifndef BBSE_MAP_SVH
`define BBSE_MAP_SVH

// status word bit positions
`define BBSE_FLAG_C 0
`define BBSE_FLAG_Z 1
`define BBSE_FLAG_N 2
`define BBSE_FLAG_V 3
`define BBSE_FLAG_S 4
`define BBSE_FLAG_H 5
`define BBSE_FLAG_T 6
`define BBSE_FLAG_I 7

// widths
`define BBSE_PC_W 12
`define BBSE_K_W 7
`define BBSE_ADR_W 5

// reset values
`define BBSE_PC_RST 12'h000
`define BBSE_FLAGS_RST 8'h00
`define BBSE_DATA_RST 8'h00

// cycle counts
`define BBSE_BR_TAKEN_CYC 2
`define BBSE_IO_BIT_CYC 2

`endif

// File: rtl/bbse_pkg.sv
// types for the branch / bit / shift execute stage
// assumes bbse_map.svh on the include path
`include "bbse_map.svh"

package bbse_pkg;

   typedef enum logic [3:0] {
      BBSE_OP_BR_PLUS = 4'h0,
      BBSE_OP_BR_GE = 4'h1,
      BBSE_OP_BR_LT = 4'h2,
      BBSE_OP_BR_HS = 4'h3,
      BBSE_OP_BR_HC = 4'h4,
      BBSE_OP_BR_TS = 4'h5,
      BBSE_OP_BR_TC = 4'h6,
      BBSE_OP_BR_VS = 4'h7,
      BBSE_OP_BR_VC = 4'h8,
      BBSE_OP_BR_IE = 4'h9,
      BBSE_OP_BR_ID = 4'ha,
      BBSE_OP_SET_IO_BIT = 4'hb,
      BBSE_OP_CLR_IO_BIT = 4'hc,
      BBSE_OP_SHIFT_LEFT = 4'hd,
      BBSE_OP_SHIFT_RIGHT = 4'he,
      BBSE_OP_ROT_CARRY = 4'hf
   } bbse_op_t;

   typedef enum logic [1:0] {
      BBSE_ST_IDLE = 2'b00,
      BBSE_ST_BRANCH = 2'b01,
      BBSE_ST_IO_BIT = 2'b10
   } bbse_fsm_t;

   typedef struct packed {
      bbse_op_t op;
      logic [`BBSE_K_W-1:0] k;
      logic [`BBSE_ADR_W-1:0] dst;
      logic [`BBSE_ADR_W-1:0] io_addr;
      logic [2:0] bit_sel;
   } bbse_cmd_t;

   typedef struct packed {
      logic [7:0] res;
      logic c;
   } bbse_shift_t;

   typedef struct packed {
      bbse_fsm_t fsm;
      logic [1:0] cnt;
      bbse_cmd_t cmd;
      logic [`BBSE_PC_W-1:0] pc;
      logic [7:0] flags;
      logic [7:0] result;
      logic ready;
      logic done;
      logic taken;
      logic [31:0][7:0] gpr;
      logic [31:0][7:0] io;
   } bbse_state_t;

endpackage

// File: verification/bbse_core_monitor.sv
// checker for bbse_core command timing and results
// assumes it is bound onto bbse_core and sees only its ports
`timescale 1ns/1ps
`include "bbse_map.svh"
module bbse_core_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire bbse_pkg::bbse_cmd_t cmd,
   input wire logic gpr_wr_en,
   input wire logic flags_wr_en,
   input wire logic cmd_ready,
   input wire logic done,
   input wire logic taken,
   input wire logic [`BBSE_PC_W-1:0] pc,
   input wire logic [7:0] flags,
   input wire logic [7:0] result,
   input wire logic [31:0][7:0] gpr_file,
   input wire logic [31:0][7:0] io_file
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic acc, br, hit, sh;
   logic [7:0] f, d;
   logic [15:0] conds;
   assign acc = cmd_valid && cmd_ready;
   assign f = flags;
   assign d = gpr_file[cmd.dst];
   assign br = cmd.op <= bbse_pkg::BBSE_OP_BR_ID;
   assign sh = cmd.op >= bbse_pkg::BBSE_OP_SHIFT_LEFT && !gpr_wr_en;
   // bit i is the branch condition of op code i
   assign conds = {5'h00, ~f[7], f[7], ~f[3], f[3], ~f[6], f[6], ~f[5],
      f[5], f[2] ^ f[3], ~(f[2] ^ f[3]), ~f[2]};
   assign hit = br && conds[cmd.op];
   sequence s_wait2;
      !done ##1 done;
   endsequence
   AST_BR_TAKEN: assert property (acc && hit |=> s_wait2 ##0
      (taken && pc == $past(pc, 2) + {{5{$past(cmd.k[6], 2)}},
      $past(cmd.k, 2)} + 12'h001))
      else $error("taken branch target or timing wrong");
   AST_BR_SKIP: assert property (acc && br && !hit |=>
      done && !taken && pc == $past(pc) + 12'h001)
      else $error("untaken branch wrong");
   AST_BR_FLAGS: assert property (acc && br && !flags_wr_en |=>
      $stable(flags)) else $error("branch changed flags");
   AST_IO_SET: assert property (acc && cmd.op == 4'hb |=>
      s_wait2 ##0 io_file[$past(cmd.io_addr, 2)][$past(cmd.bit_sel, 2)])
      else $error("io bit not set in two cycles");
   AST_IO_CLR: assert property (acc && cmd.op == 4'hc |=>
      s_wait2 ##0 !io_file[$past(cmd.io_addr, 2)][$past(cmd.bit_sel, 2)])
      else $error("io bit not cleared in two cycles");
   AST_SHL: assert property (acc && sh && cmd.op == 4'hd |=> done &&
      result == {$past(d[6:0]), 1'b0} && f[0] == $past(d[7]))
      else $error("shift left wrong");
   AST_SHR: assert property (acc && sh && cmd.op == 4'he |=> done &&
      result == {1'b0, $past(d[7:1])} && f[0] == $past(d[0]))
      else $error("shift right wrong");
   AST_ROT: assert property (acc && sh && cmd.op == 4'hf |=> done &&
      result == {$past(f[0]), $past(d[7:1])} && f[0] == $past(d[0]))
      else $error("rotate through carry wrong");
   AST_SH_FLAGS: assert property (acc && sh |=>
      f[1] == (result == 8'h00) && f[2] == result[7] && f[3] == (f[2] ^ f[0]))
      else $error("shift zero, negative or overflow flag wrong");
   AST_READY: assert property (acc && (hit || cmd.op == 4'hb ||
      cmd.op == 4'hc) |=> !cmd_ready ##1 cmd_ready)
      else $error("ready not low for exactly the wait cycle");
endmodule

bind bbse_core bbse_core_monitor mon (.clk, .srst, .cmd_valid, .cmd,
   .gpr_wr_en, .flags_wr_en, .cmd_ready, .done, .taken, .pc, .flags,
   .result, .gpr_file, .io_file);

// File: verification/bbse_core_test.sv
// self-checking bench for bbse_core
// assumes the rtl files are compiled first; inputs move on falling edges
`timescale 1ns/1ps
`include "bbse_map.svh"
module bbse_core_test;
   typedef struct packed {
      logic [3:0] op;
      logic [7:0] f;
      logic [6:0] k;
      logic tk;
   } bbse_row_t;
   logic clk, srst, cmd_valid, gpr_wr_en, flags_wr_en, io_wr_en;
   logic cmd_ready, done, taken;
   bbse_pkg::bbse_cmd_t cmd;
   logic [4:0] gpr_wr_addr, io_wr_addr;
   logic [7:0] gpr_wr_data, flags_wr_data, io_wr_data, flags, result;
   logic [11:0] pc, exp_pc;
   logic [31:0][7:0] gpr_file, io_file;
   int n_mismatch, n_tests, i;
   // a negative offset first so the target wraps below zero
   bbse_row_t rows [22] = '{
      '{4'h0, 8'h00, 7'h40, 1'b1}, '{4'h0, 8'h04, 7'h05, 1'b0},
      '{4'h1, 8'h0c, 7'h7f, 1'b1}, '{4'h1, 8'h04, 7'h3f, 1'b0},
      '{4'h2, 8'h04, 7'h3f, 1'b1}, '{4'h2, 8'h0c, 7'h01, 1'b0},
      '{4'h3, 8'h20, 7'h10, 1'b1}, '{4'h3, 8'hdf, 7'h10, 1'b0},
      '{4'h4, 8'hdf, 7'h70, 1'b1}, '{4'h4, 8'h20, 7'h70, 1'b0},
      '{4'h5, 8'h40, 7'h02, 1'b1}, '{4'h5, 8'hbf, 7'h02, 1'b0},
      '{4'h6, 8'hbf, 7'h7e, 1'b1}, '{4'h6, 8'h40, 7'h7e, 1'b0},
      '{4'h7, 8'h08, 7'h00, 1'b1}, '{4'h7, 8'hf7, 7'h00, 1'b0},
      '{4'h8, 8'hf7, 7'h41, 1'b1}, '{4'h8, 8'h08, 7'h41, 1'b0},
      '{4'h9, 8'h80, 7'h20, 1'b1}, '{4'h9, 8'h7f, 7'h20, 1'b0},
      '{4'ha, 8'h7f, 7'h60, 1'b1}, '{4'ha, 8'h80, 7'h60, 1'b0}};
   bbse_row_t r;

   bbse_core dut (
      .clk(clk),
      .srst(srst),
      .cmd_valid(cmd_valid),
      .cmd(cmd),
      .gpr_wr_en(gpr_wr_en),
      .gpr_wr_addr(gpr_wr_addr),
      .gpr_wr_data(gpr_wr_data),
      .flags_wr_en(flags_wr_en),
      .flags_wr_data(flags_wr_data),
      .io_wr_en(io_wr_en),
      .io_wr_addr(io_wr_addr),
      .io_wr_data(io_wr_data),
      .cmd_ready(cmd_ready),
      .done(done),
      .taken(taken),
      .pc(pc),
      .flags(flags),
      .result(result),
      .gpr_file(gpr_file),
      .io_file(io_file)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // w is one-hot: gpr, flags, io
   task automatic poke(input logic [2:0] w, input logic [4:0] a,
         input logic [7:0] v);
      @(negedge clk);
      {gpr_wr_en, flags_wr_en, io_wr_en} = w;
      gpr_wr_addr = a;
      io_wr_addr = a;
      gpr_wr_data = v;
      flags_wr_data = v;
      io_wr_data = v;
      @(negedge clk);
      {gpr_wr_en, flags_wr_en, io_wr_en} = 3'b000;
   endtask

   task automatic issue(input logic [3:0] op, input logic [6:0] k,
         input logic [4:0] a, input logic [2:0] b, input logic tk,
         input int n);
      int c;
      @(negedge clk);
      cmd = {op, k, a, a, b};
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      c = 1;
      // bounded wait; running out counts a mismatch and ends the run
      while (done !== 1'b1 && c < 6) begin
         @(negedge clk);
         c++;
      end
      chk(c, n);
      if (done !== 1'b1) begin
         results();
      end else begin
         exp_pc = exp_pc + (tk ? {{5{k[6]}}, k} + 12'h001 : 12'h001);
         chk(taken, tk);
         chk(pc, exp_pc);
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      {gpr_wr_en, flags_wr_en, io_wr_en} = 3'b000;
      {gpr_wr_addr, io_wr_addr, gpr_wr_data, flags_wr_data, io_wr_data} = '0;
      n_mismatch = 0;
      n_tests = 0;
      exp_pc = 12'h000;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      chk({pc, flags, result, cmd_ready, done}, 30'h2);
      $display("reset test done");
      for (i = 0; i < 22; i++) begin
         r = rows[i];
         poke(3'b010, 5'h00, r.f);
         issue(r.op, r.k, 5'h00, 3'h0, r.tk, r.tk + 1);
         chk(flags, r.f);
      end
      $display("branch table done");
      poke(3'b001, 5'h05, 8'h00);
      issue(4'hb, 7'h00, 5'h05, 3'h7, 1'b0, 2);
      chk(io_file[5], 8'h80);
      poke(3'b001, 5'h06, 8'hff);
      issue(4'hc, 7'h00, 5'h06, 3'h0, 1'b0, 2);
      chk({io_file[6], flags}, 16'hfe80);
      $display("io bit tests done");
      poke(3'b010, 5'h00, 8'h00);
      poke(3'b100, 5'h03, 8'h81);
      issue(4'hd, 7'h00, 5'h03, 3'h0, 1'b0, 1);
      chk({gpr_file[3], result, flags}, 24'h020209);
      poke(3'b100, 5'h03, 8'h01);
      issue(4'he, 7'h00, 5'h03, 3'h0, 1'b0, 1);
      chk({result, flags}, 16'h000b);
      poke(3'b010, 5'h00, 8'h21);
      poke(3'b100, 5'h03, 8'h02);
      issue(4'hf, 7'h00, 5'h03, 3'h0, 1'b0, 1);
      chk({result, flags}, 16'h812c);
      poke(3'b100, 5'h03, 8'h81);
      // two shifts on consecutive edges, second reads the first's result
      @(negedge clk);
      cmd = {4'hd, 7'h00, 5'h03, 5'h03, 3'h0};
      cmd_valid = 1'b1;
      repeat (2) @(negedge clk);
      cmd_valid = 1'b0;
      exp_pc = exp_pc + 12'h002;
      chk({gpr_file[3], flags, pc}, {8'h04, 8'h20, exp_pc});
      $display("shift tests done");
      // offer held through a taken branch's wait cycle must be ignored
      @(negedge clk);
      cmd = {4'h0, 7'h03, 5'h00, 5'h00, 3'h0};
      cmd_valid = 1'b1;
      repeat (2) @(negedge clk);
      cmd_valid = 1'b0;
      @(negedge clk);
      exp_pc = exp_pc + 12'h004;
      chk({pc, cmd_ready, done}, {exp_pc, 2'b10});
      $display("refusal test done");
      results();
   end
endmodule
